// [hdl/timer0_defines.svh]
/*
 timer0 block constants: register offsets, field positions, reset values, rates.
 assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TIMER0_DEFINES_SVH
`define TIMER0_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define T0_ADDR_COUNT 8'h00
`define T0_ADDR_OPTION 8'h04
`define T0_ADDR_STATUS 8'h08
`define T0_ADDR_MASK 8'h0c
`define T0_ADDR_WDOG 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define T0_OPT_SRC_BIT 5
`define T0_OPT_EDGE_BIT 4
`define T0_OPT_ASSIGN_BIT 3
`define T0_ST_OVF_BIT 0
`define T0_ST_WDOG_BIT 1
`define T0_WD_CLEAR_BIT 0
`define T0_WD_EN_BIT 1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define T0_OPTION_RESET 6'h00
`define T0_INSTR_DIV 4
`define T0_WDOG_BASE 64
`define T0_WRITE_INHIBIT 2'h2
`define T0_RESP_OKAY 2'h0
`define T0_RESP_SLVERR 2'h2

`endif

// [hdl/timer0_pkg.sv]
/*
 timer0 types: packed state records of the shared prescaler and the top block.
 assumes timer0_defines.svh is on the include path.
*/
package timer0_pkg;

    // ----------------------------------------
    // prescaler state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] count;
    } prescale_state_t;

    // ----------------------------------------
    // top block state
    // ----------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane;
        logic [7:0] div_cnt;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic [7:0] count;
        logic [1:0] inhibit;
        logic [5:0] option;
        logic [1:0] status;
        logic [1:0] mask;
        logic wdog_en;
        logic [7:0] wdog_base;
        logic [7:0] wdog_cnt;
        logic irq;
    } top_state_t;

endpackage : timer0_pkg

// [hdl/prescale_if.sv]
/*
 link between the timer block and its shared prescaler.
 assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface prescale_if;
    logic step;
    logic clear;
    logic [3:0] shift;
    logic pulse;
    modport user (output step, output clear, output shift, input pulse);
    modport scaler (input step, input clear, input shift, output pulse);
endinterface : prescale_if

`default_nettype wire

// [hdl/prescale_core.sv]
/*
 shared 8-bit prescaler: divides step events by two to the power of shift.
 assumes one clock and a synchronous active-high reset from the parent.
*/
`timescale 1ns/1ps
`default_nettype none

module prescale_core (
    input wire logic clk,
    input wire logic rst,
    prescale_if.scaler bus
);

    timer0_pkg::prescale_state_t cur_reg;
    timer0_pkg::prescale_state_t cur_next;

    // low bits that must all be ones for a pulse
    function automatic logic [7:0] low_mask(input logic [3:0] sh);
        logic [15:0] one_hot;
        one_hot = 16'h0001 << sh;
        low_mask = 8'(one_hot - 16'h0001);
    endfunction : low_mask

    // ----------------------------------------
    // count and output pulse
    // ----------------------------------------
    // shift zero passes every step straight through
    always_comb begin
        cur_next = cur_reg;
        bus.pulse = bus.step && !bus.clear &&
            ((cur_reg.count | ~low_mask(bus.shift)) == 8'hff);
        if (bus.clear) begin
            cur_next.count = 8'h00; // clear beats a coincident step
        end else if (bus.step) begin
            cur_next.count = cur_reg.count + 8'h01;
        end
    end

    // value stays internal, never reaches any register
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

endmodule : prescale_core

`default_nettype wire

// [hdl/timer0_top.sv]
/*
 8-bit timer/counter with shared prescaler and watchdog, behind AXI4-Lite.
 assumes one 100 MHz clock CLK, synchronous active-high RST, and an
 external count pin that may be asynchronous to CLK at the boundary.
*/
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer0_defines.svh"

module timer0_top #(
    parameter int unsigned INSTR_DIV = `T0_INSTR_DIV,
    parameter int unsigned WDOG_BASE = `T0_WDOG_BASE
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic EXTERNAL_COUNT_PIN,
    output logic IRQ
);

    // ----------------------------------------
    // state and constants
    // ----------------------------------------
    localparam timer0_pkg::top_state_t STATE_RST = '{
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        option: `T0_OPTION_RESET,
        default: '0
    };

    timer0_pkg::top_state_t cur_reg;
    timer0_pkg::top_state_t cur_next;

    logic instr_tick;
    logic pin_rise;
    logic pin_fall;
    logic pin_edge;
    logic src_sel;
    logic assign_sel;
    logic [2:0] ratio;
    logic do_write;
    logic count_write;
    logic wd_clear;
    logic timer_src;
    logic wdog_src;
    logic timer_inc;
    logic wdog_inc;

    prescale_if psc_bus();

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // a pending write that hits one register with its low lane enabled
    function automatic logic write_hit(
        input timer0_pkg::top_state_t s,
        input logic [7:0] target
    );
        write_hit = s.aw_full && s.w_full && !s.bvalid && s.w_lane &&
            (s.aw_addr == target);
    endfunction : write_hit

    // known offsets answer okay, everything else slave error
    function automatic logic [1:0] decode_resp(input logic [7:0] addr);
        case (addr)
            `T0_ADDR_COUNT,
            `T0_ADDR_OPTION,
            `T0_ADDR_STATUS,
            `T0_ADDR_MASK,
            `T0_ADDR_WDOG: decode_resp = `T0_RESP_OKAY;
            default: decode_resp = `T0_RESP_SLVERR;
        endcase
    endfunction : decode_resp

    // ----------------------------------------
    // instruction-cycle enable
    // ----------------------------------------
    // one clock in INSTR_DIV, all counting except the pin source rides on this pulse
    assign instr_tick = (cur_reg.div_cnt == 8'(INSTR_DIV - 1));

    // ----------------------------------------
    // external pin edges
    // ----------------------------------------
    // only the second and third stages are looked at, so the first may
    // settle; the pulse must stay wide enough to survive the chain
    assign pin_rise = cur_reg.pin_s2 && !cur_reg.pin_s3;
    assign pin_fall = !cur_reg.pin_s2 && cur_reg.pin_s3;
    assign pin_edge = cur_reg.option[`T0_OPT_EDGE_BIT] ? pin_fall : pin_rise;

    // ----------------------------------------
    // source selection and prescaler routing
    // ----------------------------------------
    assign src_sel = cur_reg.option[`T0_OPT_SRC_BIT];
    assign assign_sel = cur_reg.option[`T0_OPT_ASSIGN_BIT];
    assign ratio = cur_reg.option[2:0];
    assign do_write = cur_reg.aw_full && cur_reg.w_full && !cur_reg.bvalid;
    assign count_write = write_hit(cur_reg, `T0_ADDR_COUNT);
    assign wd_clear = write_hit(cur_reg, `T0_ADDR_WDOG) &&
        cur_reg.w_data[`T0_WD_CLEAR_BIT];

    // a blocked timer also holds its prescaler still
    assign timer_src = (cur_reg.inhibit == 2'h0) &&
        (src_sel ? pin_edge : instr_tick);

    // watchdog base period before any postscaling
    assign wdog_src = instr_tick && cur_reg.wdog_en &&
        (cur_reg.wdog_base == 8'(WDOG_BASE - 1));

    // the side without the prescaler gets raw events
    assign psc_bus.step = assign_sel ? wdog_src : timer_src;
    assign psc_bus.shift = assign_sel ? {1'b0, ratio} :
        {1'b0, ratio} + 4'h1;
    assign psc_bus.clear = assign_sel ? wd_clear : count_write;
    assign timer_inc = assign_sel ? timer_src : psc_bus.pulse;
    assign wdog_inc = assign_sel ? psc_bus.pulse : wdog_src;

    // prescaler count has no path to the register file
    prescale_core u_prescale (
        .clk(CLK),
        .rst(RST),
        .bus(psc_bus)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic [1:0] st_set;
        logic [1:0] st_clr;
        st_set = 2'h0;
        st_clr = 2'h0;
        cur_next = cur_reg;

        // instruction-cycle divider
        cur_next.div_cnt = instr_tick ? 8'h00 : cur_reg.div_cnt + 8'h01;

        // pin synchroniser and edge history
        cur_next.pin_s1 = EXTERNAL_COUNT_PIN;
        cur_next.pin_s2 = cur_reg.pin_s1;
        cur_next.pin_s3 = cur_reg.pin_s2;

        // write inhibit runs down on instruction cycles only
        if (instr_tick && cur_reg.inhibit != 2'h0) begin
            cur_next.inhibit = cur_reg.inhibit - 2'h1;
        end

        // timer counter, wraps through zero
        if (timer_inc) begin
            cur_next.count = cur_reg.count + 8'h01;
            if (cur_reg.count == 8'hff) begin
                st_set[`T0_ST_OVF_BIT] = 1'b1;
            end
        end

        // watchdog base divider and counter
        if (instr_tick && cur_reg.wdog_en) begin
            cur_next.wdog_base = (cur_reg.wdog_base == 8'(WDOG_BASE - 1)) ?
                8'h00 : cur_reg.wdog_base + 8'h01;
        end
        if (wdog_inc) begin
            cur_next.wdog_cnt = cur_reg.wdog_cnt + 8'h01;
            if (cur_reg.wdog_cnt == 8'hff) begin
                st_set[`T0_ST_WDOG_BIT] = 1'b1;
            end
        end

        // write address and data are taken independently
        if (AWVALID && cur_reg.awready) begin
            cur_next.aw_full = 1'b1;
            cur_next.aw_addr = AWADDR;
        end
        if (WVALID && cur_reg.wready) begin
            cur_next.w_full = 1'b1;
            cur_next.w_data = WDATA[7:0];
            cur_next.w_lane = WSTRB[0];
        end

        // response first drains, then a held pair may complete
        if (BREADY && cur_reg.bvalid) begin
            cur_next.bvalid = 1'b0;
        end
        if (do_write) begin
            cur_next.aw_full = 1'b0;
            cur_next.w_full = 1'b0;
            cur_next.bvalid = 1'b1;
            cur_next.bresp = decode_resp(cur_reg.aw_addr);
        end

        // register effects; a counter write beats a same-cycle increment
        if (count_write) begin
            cur_next.count = cur_reg.w_data;
            cur_next.inhibit = `T0_WRITE_INHIBIT;
        end
        if (write_hit(cur_reg, `T0_ADDR_OPTION)) begin
            cur_next.option = cur_reg.w_data[5:0];
        end
        if (write_hit(cur_reg, `T0_ADDR_STATUS)) begin
            st_clr = cur_reg.w_data[1:0];
        end
        if (write_hit(cur_reg, `T0_ADDR_MASK)) begin
            cur_next.mask = cur_reg.w_data[1:0];
        end
        if (write_hit(cur_reg, `T0_ADDR_WDOG)) begin
            cur_next.wdog_en = cur_reg.w_data[`T0_WD_EN_BIT];
        end
        if (wd_clear) begin
            cur_next.wdog_cnt = 8'h00;
            cur_next.wdog_base = 8'h00;
        end

        // sticky flags: a new event outlasts a same-cycle clear
        cur_next.status = (cur_reg.status & ~st_clr) | st_set;

        // ready only while the holding slot is empty
        cur_next.awready = !cur_next.aw_full;
        cur_next.wready = !cur_next.w_full;

        // one read at a time, answered the edge after the address
        if (RREADY && cur_reg.rvalid) begin
            cur_next.rvalid = 1'b0;
            cur_next.arready = 1'b1;
        end
        if (ARVALID && cur_reg.arready) begin
            cur_next.arready = 1'b0;
            cur_next.rvalid = 1'b1;
            cur_next.rresp = decode_resp(ARADDR);
            case (ARADDR)
                `T0_ADDR_COUNT: cur_next.rdata = {24'h000000, cur_reg.count};
                `T0_ADDR_OPTION: cur_next.rdata = {26'h0000000, cur_reg.option};
                `T0_ADDR_STATUS: cur_next.rdata = {30'h00000000, cur_reg.status};
                `T0_ADDR_MASK: cur_next.rdata = {30'h00000000, cur_reg.mask};
                `T0_ADDR_WDOG: cur_next.rdata = {16'h0000, cur_reg.wdog_cnt,
                    6'h00, cur_reg.wdog_en, 1'b0};
                default: cur_next.rdata = 32'h00000000;
            endcase
        end

        // level interrupt from the masked flags, registered on the same edge as them
        cur_next.irq = |(cur_next.status & cur_next.mask);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            cur_reg <= STATE_RST;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    assign AWREADY = cur_reg.awready;
    assign WREADY = cur_reg.wready;
    assign BVALID = cur_reg.bvalid;
    assign BRESP = cur_reg.bresp;
    assign ARREADY = cur_reg.arready;
    assign RVALID = cur_reg.rvalid;
    assign RRESP = cur_reg.rresp;
    assign RDATA = cur_reg.rdata;
    assign IRQ = cur_reg.irq;

endmodule : timer0_top

`default_nettype wire

// [verification/timer0_asserts.sv]
/* checker of the timer block's bus and interrupt ports.
   assumes it is bound into timer0_top and sees a single clock. */
`timescale 1ns/1ps
`default_nettype none
module timer0_asserts (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ARADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic IRQ
);
    // ----
    // properties
    // ----
    logic aw_hs;
    // an interrupt may only drop after a register write was taken
    assign aw_hs = AWVALID && AWREADY;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    aw_close_a: assert property (aw_hs |=> !AWREADY)
        else $error("write address slot stayed open");
    w_close_a: assert property (WVALID && WREADY |=> !WREADY)
        else $error("write data slot stayed open");
    b_answer_a: assert property (aw_hs && WVALID && WREADY && !BVALID |-> ##[1:2] BVALID)
        else $error("write response late");
    b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    r_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late");
    r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    hidden_read_a: assert property (ARVALID && ARREADY && ARADDR > 8'h13 |=> RRESP == 2'h2 && RDATA == 32'h0)
        else $error("unmapped read answered");
    irq_sticky_a: assert property ($fell(IRQ) |-> $past(aw_hs, 2) || $past(aw_hs, 3) || $past(aw_hs, 4))
        else $error("interrupt dropped without a write");
endmodule : timer0_asserts
bind timer0_top timer0_asserts u_chk (
    .CLK(CLK), .RST(RST), .ARADDR(ARADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .IRQ(IRQ)
);
`default_nettype wire

// [verification/count_source.sv]
/* model of the source on the external count pin.
   assumes its tasks are called just after a rising clk edge. */
`timescale 1ns/1ps
`default_nettype none
module count_source (
    input wire logic clk,
    output logic pin
);
    // ----
    // pin drive
    // ----
    initial pin = 1'h0;
    // each level held four cycles: the synchroniser needs three
    task automatic level(input logic v);
        pin <= v;
        repeat (4) @(posedge clk);
    endtask : level
    // n rising edges, pin left high
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            level(1'h0);
            level(1'h1);
        end
    endtask : burst
endmodule : count_source
`default_nettype wire

// [verification/tb_top.sv]
/* self-checking bench of the timer block over its register bus.
   assumes the design takes short watchdog base counts in simulation. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int ID = 4;
    localparam int WB = 2;
    logic CLK;
    logic RST = 1'h1;
    logic [7:0] AWADDR = 8'h00;
    logic [7:0] ARADDR = 8'h00;
    logic AWVALID = 1'h0;
    logic WVALID = 1'h0;
    logic ARVALID = 1'h0;
    // ready lines high except in the stall check: answers are taken at once
    logic BREADY = 1'h1;
    logic RREADY = 1'h1;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'h1;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, pin;
    logic [1:0] BRESP, RRESP, r;
    logic [31:0] RDATA, d;
    logic [7:0] v;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'ha70e;
    int t0;

    timer0_top #(.INSTR_DIV(ID), .WDOG_BASE(WB)) i_dut (
        .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .EXTERNAL_COUNT_PIN(pin), .IRQ(IRQ)
    );
    count_source i_src (.clk(CLK), .pin(pin));

    // ----
    // clock and cycle count
    // ----
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;

    // ----
    // bus tasks and checks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // both channels offered together, each released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        AWADDR <= a;
        WDATA <= {24'h0, x};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        fork
            begin
                do @(posedge CLK); while (!AWREADY);
                AWVALID <= 1'h0;
            end
            begin
                do @(posedge CLK); while (!WREADY);
                WVALID <= 1'h0;
            end
        join
        do @(posedge CLK); while (!BVALID);
        r = BRESP;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'h1;
        do @(posedge CLK); while (!ARREADY);
        ARVALID <= 1'h0;
        do @(posedge CLK); while (!RVALID);
        d = RDATA;
        r = RRESP;
    endtask : rd
    // start the next transfer n edges after t0, keeping windows exact
    task automatic at(input int n);
        while (cyc - t0 < n) @(posedge CLK);
    endtask : at
    // counter advance over a window that holds whole prescaler periods
    task automatic delta(input int span, input logic [7:0] e);
        logic [7:0] c0;
        t0 = cyc;
        rd(8'h00);
        c0 = d[7:0];
        at(span);
        rd(8'h00);
        check(8'(d[7:0] - c0), e, "count delta");
    endtask : delta
    task automatic ext(input int n, input logic drop, input logic [7:0] e);
        logic [7:0] c0;
        rd(8'h00);
        c0 = d[7:0];
        i_src.burst(n);
        if (drop) begin
            i_src.level(1'h0);
        end
        repeat (6) @(posedge CLK);
        rd(8'h00);
        check(8'(d[7:0] - c0), e, "pin count");
    endtask : ext
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ----
    // watchdog and main sequence
    // ----
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        for (int a = 4; a < 20; a += 4) begin
            rd(8'(a));
            check(d, 32'h0, "reset value");
        end
        rd(8'h14);
        check(r, 2'h2, "unmapped read");
        wr(8'h14, 8'h55);
        check(r, 2'h2, "unmapped write");
        $display("test reset done");
        wr(8'h04, 8'h08);
        delta(16 * ID, 8'h10);
        for (int f = 0; f < 8; f++) begin
            wr(8'h04, 8'(f));
            delta((4 * ID) << f, 8'h02);
        end
        $display("test ratios done");
        wr(8'h04, 8'h28);
        ext(5, 1'h0, 8'h05);
        wr(8'h04, 8'h38);
        ext(3, 1'h1, 8'h04);
        $display("test pin done");
        wr(8'h04, 8'h08);
        wr(8'h08, 8'h01);
        v = 8'hf2 | 8'($random(seed));
        t0 = cyc;
        wr(8'h00, v);
        at(66);
        rd(8'h00);
        check(d, {24'h0, v + 8'h0e}, "count after write");
        rd(8'h08);
        check(d, 32'h1, "overflow flag");
        check(IRQ, 32'h0, "masked irq");
        wr(8'h0c, 8'h01);
        repeat (2) @(posedge CLK);
        check(IRQ, 32'h1, "irq raised");
        wr(8'h08, 8'h01);
        repeat (2) @(posedge CLK);
        check(IRQ, 32'h0, "irq cleared");
        // a write with its low lane off is okayed but must leave option alone
        WSTRB <= 4'h0;
        wr(8'h04, 8'h3f);
        WSTRB <= 4'h1;
        check(r, 2'h0, "lane write okay");
        // answers held back a few cycles so the hold checks see a stall
        BREADY <= 1'h0;
        RREADY <= 1'h0;
        wr(8'h0c, 8'h00);
        rd(8'h04);
        repeat (3) @(posedge CLK);
        BREADY <= 1'h1;
        RREADY <= 1'h1;
        @(posedge CLK);
        check(d, 32'h08, "lane write ignored");
        $display("test overflow done");
        wr(8'h04, 8'h01);
        t0 = cyc;
        wr(8'h00, 8'($random(seed)));
        at(21);
        v = 8'($random(seed));
        wr(8'h00, v);
        at(43);
        rd(8'h00);
        check(d, {24'h0, v}, "count held");
        rd(8'h04);
        check(d, 32'h1, "option kept");
        $display("test prescaler clear done");
        wr(8'h10, 8'h02);
        for (int f = 0; f < 2; f++) begin
            wr(8'h04, 8'h08 | 8'(f));
            t0 = cyc;
            wr(8'h10, 8'h03);
            at(2 + ((3 * ID * WB) << f));
            rd(8'h10);
            check(d, 32'h0302, "watchdog count");
        end
        $display("test watchdog done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
